// File: src/dlt_target.sv
// die link target: link decode, register store, pin and wake control
`timescale 1ns/1ps
`default_nettype none
`include "dlt_map.svh"
// Functional notes
// - target ignores link in sleep, and in stop except for the wake command
// - stop mode wake pulses interrupt line
// - wake command in stop raises wake
// - link clock pin input only, pulled
// - data pins bidirectional, pull-down always on
// - interrupt line output only, never sampled
// - sleep pulls all data pins down
// - write: command, address, data stored
// - read: command, address, data returned
module dlt_target (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic [1:0] power_mode_i,
	input wire logic link_clock_pin_i,
	input wire logic [7:0] link_data_pins_i,
	output logic [7:0] link_data_pins_o,
	output logic [7:0] link_data_pins_oe_o,
	output logic [7:0] link_data_pulldown_o,
	output logic link_clock_pull_o,
	output logic link_clock_oe_o,
	output logic wake_irq_line_o,
	output logic wake_request_o
);
	// ==========================================
	// pin synchronisation
	logic clk_q;
	logic clk_rise;
	logic clk_fall;
	logic [7:0] data_q;
	dlt_sync u_clk_sync (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.d_i(link_clock_pin_i),
		.q_o(clk_q),
		.rise_o(clk_rise),
		.fall_o(clk_fall)
	);
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_data_sync
			dlt_sync u_data_sync (
				.sys_clk_i(sys_clk_i),
				.rst_i(rst_i),
				.d_i(link_data_pins_i[gi]),
				.q_o(data_q[gi]),
				.rise_o(),
				.fall_o()
			);
		end
	endgenerate
	// ==========================================
	// mode tracking
	logic [1:0] mode;
	logic [1:0] mode_prev;
	logic active;
	logic resume;
	logic clk_seen;
	assign active = (mode == `DLT_MODE_NORMAL);
	assign resume = active && (mode_prev != `DLT_MODE_NORMAL);
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			mode <= `DLT_MODE_NORMAL;
			mode_prev <= `DLT_MODE_NORMAL;
		end else begin
			mode <= power_mode_i;
			mode_prev <= mode;
		end
	end
	// ==========================================
	// link clock qualification: wait for the initiator to drive the clock low
	always_ff @(posedge sys_clk_i) begin
		if (rst_i || !active || resume) begin
			clk_seen <= 1'b0;
		end else if (!clk_q) begin
			clk_seen <= 1'b1;
		end
	end
	// ==========================================
	// transaction decode
	dlt_pkg::dlt_state_e state;
	logic [7:0] cmd;
	logic [7:0] addr;
	logic [7:0] regs [0:255];
	logic go;
	assign go = active && clk_seen && clk_rise;
	always_ff @(posedge sys_clk_i) begin
		if (rst_i || !active || resume) begin
			state <= dlt_pkg::DLT_IDLE;
			cmd <= 8'h00;
			addr <= 8'h00;
		end else if (go) begin
			case (state)
				dlt_pkg::DLT_IDLE: begin
					cmd <= data_q;
					if (data_q == `DLT_CMD_WRITE || data_q == `DLT_CMD_READ) begin
						state <= dlt_pkg::DLT_ADDR;
					end
				end
				dlt_pkg::DLT_ADDR: begin
					addr <= data_q;
					if (cmd == `DLT_CMD_WRITE) begin
						state <= dlt_pkg::DLT_WDATA;
					end else begin
						state <= dlt_pkg::DLT_RDATA;
					end
				end
				dlt_pkg::DLT_WDATA: begin
					state <= dlt_pkg::DLT_IDLE;
				end
				dlt_pkg::DLT_RDATA: begin
					state <= dlt_pkg::DLT_RDONE;
				end
				dlt_pkg::DLT_RDONE: begin
					state <= dlt_pkg::DLT_IDLE;
				end
				default: begin
					state <= dlt_pkg::DLT_IDLE;
				end
			endcase
		end else if (clk_fall && state == dlt_pkg::DLT_RDONE) begin
			state <= dlt_pkg::DLT_IDLE;
		end
	end
	// ==========================================
	// register store
	always_ff @(posedge sys_clk_i) begin
		if (go && state == dlt_pkg::DLT_WDATA) begin
			regs[addr] <= data_q;
		end
	end
	// ==========================================
	// read data drive: launched at the address rise, held until the clock falls after the read data rise
	logic [7:0] rd_data;
	logic rd_drive;
	always_ff @(posedge sys_clk_i) begin
		if (rst_i || !active || resume) begin
			rd_drive <= 1'b0;
		end else if (go && state == dlt_pkg::DLT_ADDR && cmd == `DLT_CMD_READ) begin
			rd_drive <= 1'b1;
		end else if (clk_fall && state == dlt_pkg::DLT_RDONE) begin
			rd_drive <= 1'b0;
		end
	end
	always_ff @(posedge sys_clk_i) begin
		if (rst_i || !active || resume) begin
			rd_data <= `DLT_REG_RESET;
		end else if (go && state == dlt_pkg::DLT_ADDR && cmd == `DLT_CMD_READ) begin
			rd_data <= regs[data_q];
		end
	end
	// ==========================================
	// pin control
	// data pins drive from the address rise of a read until the clock falls after the read data rise
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			link_data_pins_o <= 8'h00;
			link_data_pins_oe_o <= 8'h00;
		end else begin
			link_data_pins_o <= rd_data;
			link_data_pins_oe_o <= (active && rd_drive) ? 8'hff : 8'h00;
		end
	end
	// data pull-downs stay on in every mode and drive direction
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			link_data_pulldown_o <= 8'hff;
		end else begin
			link_data_pulldown_o <= 8'hff;
		end
	end
	// clock pin is an input with its pull kept on
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			link_clock_pull_o <= 1'b1;
			link_clock_oe_o <= 1'b0;
		end else begin
			link_clock_pull_o <= 1'b1;
			link_clock_oe_o <= 1'b0;
		end
	end
	// ==========================================
	// stop mode wake: command seen in stop, interrupt pulse on re-enable
	logic stop_wake_cmd;
	logic [7:0] pulse_cnt;
	logic was_stop;
	assign stop_wake_cmd = (mode == `DLT_MODE_STOP) && clk_rise && (data_q == `DLT_CMD_WAKE);
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			was_stop <= 1'b0;
		end else begin
			was_stop <= (mode == `DLT_MODE_STOP);
		end
	end
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			wake_request_o <= 1'b0;
		end else begin
			wake_request_o <= stop_wake_cmd;
		end
	end
	// ==========================================
	// interrupt pulse after leaving stop
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			pulse_cnt <= 8'h00;
			wake_irq_line_o <= 1'b0;
		end else if (resume && was_stop) begin
			pulse_cnt <= 8'(`DLT_WAKE_PULSE_CYC);
			wake_irq_line_o <= 1'b1;
		end else if (pulse_cnt != 8'h00) begin
			pulse_cnt <= pulse_cnt - 8'h01;
			wake_irq_line_o <= (pulse_cnt != 8'h01);
		end else begin
			wake_irq_line_o <= 1'b0;
		end
	end
endmodule : dlt_target
`default_nettype wire

// File: inc/dlt_map.svh
// constants for the die link target: commands, timing, power modes and register reset
`ifndef DLT_MAP_SVH
`define DLT_MAP_SVH
`define DLT_CMD_WRITE 8'h01
`define DLT_CMD_READ 8'h02
`define DLT_CMD_WAKE 8'h5a
`define DLT_WAKE_PULSE_NS 1000
`define DLT_CLK_NS 40
`define DLT_WAKE_PULSE_CYC ((`DLT_WAKE_PULSE_NS + `DLT_CLK_NS - 1) / `DLT_CLK_NS)
`define DLT_MODE_NORMAL 2'h0
`define DLT_MODE_SLEEP 2'h1
`define DLT_MODE_STOP 2'h2
`define DLT_REG_RESET 8'h00
`endif

// File: inc/dlt_pkg.sv
// types for the die link target
`default_nettype none
package dlt_pkg;
	typedef enum logic [2:0] {
		DLT_IDLE,
		DLT_ADDR,
		DLT_WDATA,
		DLT_RDATA,
		DLT_RDONE
	} dlt_state_e;
endpackage : dlt_pkg
`default_nettype wire

// File: src/dlt_sync.sv
// two-flop synchroniser with edge outputs
`timescale 1ns/1ps
`default_nettype none
module dlt_sync (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic d_i,
	output logic q_o,
	output logic rise_o,
	output logic fall_o
);
	logic meta;
	logic sync;
	logic prev;
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			meta <= 1'b0;
			sync <= 1'b0;
			prev <= 1'b0;
		end else begin
			meta <= d_i;
			sync <= meta;
			prev <= sync;
		end
	end
	assign q_o = sync;
	assign rise_o = sync & ~prev;
	assign fall_o = ~sync & prev;
endmodule : dlt_sync
`default_nettype wire

// File: test/dlt_target_assertions.sv
// checker for the die link target pins
`timescale 1ns/1ps
`default_nettype none
module dlt_target_assertions (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic [1:0] power_mode_i,
	input wire logic [7:0] link_data_pins_oe_o,
	input wire logic [7:0] link_data_pulldown_o,
	input wire logic link_clock_pull_o,
	input wire logic link_clock_oe_o,
	input wire logic wake_irq_line_o,
	input wire logic wake_request_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	sequence s_irq_hold;
		wake_irq_line_o [*8] ##[1:30] !wake_irq_line_o;
	endsequence
	a_pull_down: assert property (link_data_pulldown_o == 8'hff) else $error("pull");
	a_clk_pull: assert property (link_clock_pull_o) else $error("clk pull");
	a_clk_input: assert property (!link_clock_oe_o) else $error("clk oe");
	a_oe_whole: assert property (
		link_data_pins_oe_o == 8'h00 || link_data_pins_oe_o == 8'hff) else $error("oe");
	a_off_quiet: assert property (
		(power_mode_i != 2'h0) [*3] |-> link_data_pins_oe_o == 8'h00) else $error("oe off");
	a_irq_normal: assert property (
		$rose(wake_irq_line_o) |-> power_mode_i == 2'h0) else $error("irq mode");
	a_irq_len: assert property ($rose(wake_irq_line_o) |-> s_irq_hold) else $error("irq");
	a_req_stop: assert property (
		wake_request_o |-> $past(power_mode_i, 2) == 2'h2) else $error("req mode");
	a_req_pulse: assert property (wake_request_o |=> !wake_request_o) else $error("req");
endmodule : dlt_target_assertions
bind dlt_target dlt_target_assertions i_dlt_target_assertions (.sys_clk_i(sys_clk_i),
	.rst_i(rst_i), .power_mode_i(power_mode_i), .link_data_pins_oe_o(link_data_pins_oe_o),
	.link_data_pulldown_o(link_data_pulldown_o), .link_clock_pull_o(link_clock_pull_o),
	.link_clock_oe_o(link_clock_oe_o), .wake_irq_line_o(wake_irq_line_o),
	.wake_request_o(wake_request_o));
`default_nettype wire

// File: test/dlt_init_model.sv
// link initiator model
`timescale 1ns/1ps
`default_nettype none
module dlt_init_model (
	input wire logic [7:0] pins_i,
	output logic clk_o,
	output logic [7:0] dat_o,
	output logic drv_o
);
	initial begin
		clk_o = 1'b0;
		dat_o = 8'h00;
		drv_o = 1'b0;
	end
	// one byte per rise, clock low between bytes
	task xfer(input logic [7:0] b, input logic rel, output logic [7:0] q);
		drv_o = !rel;
		dat_o = b;
		#160 clk_o = 1'b1;
		q = pins_i;
		#160 clk_o = 1'b0;
		drv_o = 1'b0;
		#200;
	endtask : xfer
endmodule : dlt_init_model
`default_nettype wire

// File: test/testbench.sv
// testbench for the die link target
`timescale 1ns/1ps
`default_nettype none
`include "dlt_map.svh"
module testbench;
	logic sys_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [1:0] mode = 2'h0;
	logic lclk, drv, wreq, irq;
	int wreq_cnt = 0;
	logic [7:0] mdat, pins, dout, oe, q;
	int err_total = 0;
	int checked = 0;
	always #20 sys_clk_i = !sys_clk_i;
	assign pins = (oe & dout) | (~oe & (drv ? mdat : 8'h00));
	always @(posedge sys_clk_i) if (wreq) wreq_cnt <= wreq_cnt + 1;
	dlt_target i_dlt_target (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .power_mode_i(mode),
		.link_clock_pin_i(lclk), .link_data_pins_i(pins), .link_data_pins_o(dout),
		.link_data_pins_oe_o(oe), .link_data_pulldown_o(), .link_clock_pull_o(),
		.link_clock_oe_o(), .wake_irq_line_o(irq), .wake_request_o(wreq));
	dlt_init_model i_dlt_init_model (.pins_i(pins), .clk_o(lclk), .dat_o(mdat), .drv_o(drv));
	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("wrong value %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task test_done;
		$display("checked %0d errors %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : test_done
	task wr(input logic [7:0] a, input logic [7:0] d);
		i_dlt_init_model.xfer(`DLT_CMD_WRITE, 1'b0, q);
		i_dlt_init_model.xfer(a, 1'b0, q);
		i_dlt_init_model.xfer(d, 1'b0, q);
	endtask : wr
	task rd(input logic [7:0] a, output logic [7:0] d);
		i_dlt_init_model.xfer(`DLT_CMD_READ, 1'b0, q);
		i_dlt_init_model.xfer(a, 1'b0, q);
		i_dlt_init_model.xfer(8'h00, 1'b1, d);
	endtask : rd
	task t_rw;
		logic [7:0] d;
		wr(8'h00, 8'hc3);
		wr(8'hff, 8'h3c);
		rd(8'h00, d);
		chk("rd 00", 8'hc3, d);
		rd(8'hff, d);
		chk("rd ff", 8'h3c, d);
	endtask : t_rw
	task t_sleep;
		logic [7:0] d;
		@(negedge sys_clk_i) mode = `DLT_MODE_SLEEP;
		wr(8'h00, 8'h77);
		rd(8'h00, d);
		chk("sleep rd", 8'h00, d);
		@(negedge sys_clk_i) mode = `DLT_MODE_NORMAL;
		rd(8'h00, d);
		chk("rd after", 8'hc3, d);
	endtask : t_sleep
	task t_stop;
		int n0;
		@(negedge sys_clk_i) mode = `DLT_MODE_STOP;
		n0 = wreq_cnt;
		i_dlt_init_model.xfer(`DLT_CMD_WAKE, 1'b0, q);
		chk("wake req", 8'h01, 8'(wreq_cnt - n0));
		@(negedge sys_clk_i) mode = `DLT_MODE_NORMAL;
		for (int i = 0; i < 100 && irq !== 1'b1; i++) @(negedge sys_clk_i);
		chk("wake irq", 8'h01, {7'h00, irq});
		if (irq !== 1'b1) test_done();
		repeat (40) @(negedge sys_clk_i);
		chk("wake irq end", 8'h00, {7'h00, irq});
	endtask : t_stop
	initial begin
		repeat (16) @(negedge sys_clk_i);
		rst_i = 1'b0;
		repeat (4) @(negedge sys_clk_i);
		t_rw();
		t_sleep();
		t_stop();
		test_done();
	end
endmodule : testbench
`default_nettype wire
